/* File: shared/flash_sec_pkg.sv */
// shared constants and carriers of the flash security and protection block
package flash_sec_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFF_OPTION = 8'h00;
	localparam logic [7:0] OFF_CONFIG = 8'h04;
	localparam logic [7:0] OFF_PROTECT = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	// field positions
	localparam int BIT_KEY_EN = 7;
	localparam int BIT_NO_REDIR = 6;
	localparam int BIT_KEY_ACC = 5;
	localparam int BIT_CFG_ONE = 6;
	localparam int BIT_VIOL = 5;
	localparam int BIT_SECURE = 0;
	// lock state codes
	localparam logic [1:0] LOCK_UNSEC = 2'h2;
	// protect select encodings and region geometry
	localparam logic [5:0] PS_NONE = 6'h3F;
	localparam logic [5:0] PS_FULL_MAX = 6'h18;
	localparam logic [16:0] MEM_TOP = 17'h10000;
	localparam logic [16:0] PS_STEP = 17'h00600;
	// key window base address
	localparam logic [15:0] KEY_WIN_BASE = 16'hFFB0;
	localparam logic [31:0] RD_ZERO = 32'h00000000;

	// one write into the key window
	typedef struct packed {
		logic valid;
		logic from_debug;
		logic [2:0] index;
		logic [7:0] data;
	} key_wr_t;

	// one program or erase command to be checked
	typedef struct packed {
		logic valid;
		logic mass;
		logic [15:0] addr;
	} flash_cmd_t;
endpackage

/* File: src/flash_security_protection.sv */
// flash option, security, key window and protection control
// Notes on behaviour
// - every reset copies the nonvolatile option byte into the read-only option register
// - key comparison cannot unlock while backdoor_key_enable is zero
// - key writes are taken only from secure firmware, never from debug
// - eight matching key bytes in ascending order unlock until next reset
// - vector_redirect_disable one disables redirection, zero enables it
// - only lock_state_code 1:0 means unsecured, all others secure
// - while secure, unsecured-source accesses to memory are blocked
// - key match or all-erased blank check sets lock_state_code to 1:0
// - key_write_access zero routes window writes to commands, one to key compare
// - reset loads the protection register from the nonvolatile protection byte
// - protection register always readable, writes only grow the region
// - program or erase into a protected area is refused and flagged
// - mass erase refused whenever any sector is protected
// - protect_select 0x3F none, 0x3E top 1.5K, lower codes grow downward
// - violation flag clears by writing one; offending command ignored
// - clearing key_write_access compares the key and unlocks on a match
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module flash_security_protection #(
	parameter int KEY_BYTES = 8,
	parameter int ADR_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [7:0] nv_option_byte_i,
	input wire logic [7:0] nv_protection_byte_i,
	input wire logic [8*KEY_BYTES-1:0] nv_backdoor_key_i,
	input wire flash_sec_pkg::key_wr_t key_wr_i,
	input wire flash_sec_pkg::flash_cmd_t cmd_i,
	input wire logic blank_pass_i,
	input wire logic acc_req_i,
	input wire logic acc_secure_src_i,
	output logic acc_block_o,
	output logic cmd_start_o,
	output logic cmd_accept_o,
	output logic secure_o,
	output logic vector_redirect_en_o
);
	// the key buffer and the register decode serve only these sizes
	if (KEY_BYTES != 8 || ADR_W < 4) begin : param_check
		$error("key must be eight bytes and address at least four bits");
	end

	logic [7:0] opt_q;
	logic [1:0] lock_q;
	logic key_acc_q;
	logic cfg_one_q;
	logic [5:0] ps_q;
	logic viol_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic [7:0] key_buf_q [KEY_BYTES];
	logic [3:0] key_cnt_q;

	// bus decode; writes act at the edge where the master sees ack
	// reads have no side effect, so only the write path is gated by ack
	wire logic req = cyc_i & stb_i;
	wire logic wr = req & we_i & ack_q & sel_i[0];
	wire logic [7:0] off = 8'(adr_i);
	wire logic hit_cfg = off == flash_sec_pkg::OFF_CONFIG;
	wire logic hit_prot = off == flash_sec_pkg::OFF_PROTECT;
	wire logic hit_stat = off == flash_sec_pkg::OFF_STATUS;
	wire logic wr_cfg = wr & hit_cfg;
	wire logic wr_prot = wr & hit_prot;
	wire logic wr_stat = wr & hit_stat;

	// security decode: only 1:0 is unsecured
	wire logic secure = lock_q != flash_sec_pkg::LOCK_UNSEC;
	wire logic key_en = opt_q[flash_sec_pkg::BIT_KEY_EN];

	// key window steering
	wire logic kw = key_wr_i.valid;
	wire logic kw_key = kw & key_acc_q;
	wire logic kw_take = kw_key & key_en & ~key_wr_i.from_debug;
	wire logic kw_order = key_wr_i.index == 3'(key_cnt_q);
	wire logic key_full = key_cnt_q == 4'(KEY_BYTES);

	// compare buffered bytes against the stored key, ascending order
	logic key_same;
	always_comb begin
		key_same = 1'b1;
		for (int i = 0; i < KEY_BYTES; i++) begin
			if (key_buf_q[i] != nv_backdoor_key_i[8*i +: 8]) begin
				key_same = 1'b0;
			end
		end
	end

	// key sequence ends when software clears key_write_access
	wire logic acc_fall = wr_cfg & key_acc_q & ~dat_i[flash_sec_pkg::BIT_KEY_ACC];
	wire logic key_match = acc_fall & key_en & key_full & key_same;
	wire logic unlock = key_match | blank_pass_i;

	// protected region: start address, code 0x3F protects nothing
	wire logic [16:0] ps_span = 17'(flash_sec_pkg::PS_NONE - ps_q) * flash_sec_pkg::PS_STEP;
	wire logic ps_full = ps_q <= flash_sec_pkg::PS_FULL_MAX;
	wire logic [16:0] ps_start = ps_full ? 17'h00000 : flash_sec_pkg::MEM_TOP - ps_span;
	wire logic any_prot = ps_q != flash_sec_pkg::PS_NONE;
	wire logic addr_prot = any_prot & ({1'b0, cmd_i.addr} >= ps_start);
	wire logic cmd_bad = cmd_i.mass ? any_prot : addr_prot;
	wire logic refuse = cmd_i.valid & cmd_bad;

	// protection writes accepted only when the region does not shrink
	wire logic [5:0] ps_new = dat_i[5:0];
	wire logic ps_grow = ps_new <= ps_q;

	// read mux; reserved and unmapped bits read zero
	logic [31:0] rdata;
	always_comb begin
		rdata = flash_sec_pkg::RD_ZERO;
		unique case (off)
			flash_sec_pkg::OFF_OPTION: rdata[7:0] = {opt_q[7:2], lock_q};
			flash_sec_pkg::OFF_CONFIG: begin
				rdata[flash_sec_pkg::BIT_CFG_ONE] = cfg_one_q;
				rdata[flash_sec_pkg::BIT_KEY_ACC] = key_acc_q;
			end
			flash_sec_pkg::OFF_PROTECT: rdata[5:0] = ps_q;
			flash_sec_pkg::OFF_STATUS: begin
				rdata[flash_sec_pkg::BIT_VIOL] = viol_q;
				rdata[flash_sec_pkg::BIT_SECURE] = secure;
			end
			default: rdata = flash_sec_pkg::RD_ZERO;
		endcase
	end

	// bus slave: ack one cycle after request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= flash_sec_pkg::RD_ZERO;
		end else begin
			ack_q <= req & ~ack_q;
			dat_q <= rdata;
		end
	end

	// option and lock state load at reset; only unlock alters lock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			opt_q <= nv_option_byte_i;
			lock_q <= nv_option_byte_i[1:0];
		end else if (unlock) begin
			lock_q <= flash_sec_pkg::LOCK_UNSEC;
		end
	end

	// configuration bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			key_acc_q <= 1'b0;
			cfg_one_q <= 1'b0;
		end else if (wr_cfg) begin
			key_acc_q <= dat_i[flash_sec_pkg::BIT_KEY_ACC];
			cfg_one_q <= dat_i[flash_sec_pkg::BIT_CFG_ONE];
		end
	end

	// protection register: loaded at reset, then grow-only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ps_q <= nv_protection_byte_i[5:0];
		end else if (wr_prot & ps_grow) begin
			ps_q <= ps_new;
		end
	end

	// violation flag: a new violation wins over the clear
	// the offending command itself is dropped through cmd_accept_o
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			viol_q <= 1'b0;
		end else if (refuse) begin
			viol_q <= 1'b1;
		end else if (wr_stat & dat_i[flash_sec_pkg::BIT_VIOL]) begin
			viol_q <= 1'b0;
		end
	end

	// key capture; an out-of-order byte restarts the sequence
	always_ff @(posedge clk_i) begin
		if (rst_i || acc_fall) begin
			key_cnt_q <= 4'h0;
		end else if (kw_take && !key_full) begin
			key_cnt_q <= kw_order ? key_cnt_q + 4'h1 : 4'h0;
		end
	end

	// key byte storage, no reset needed since the count qualifies it
	always_ff @(posedge clk_i) begin
		if (kw_take && kw_order && !key_full) begin
			key_buf_q[key_wr_i.index] <= key_wr_i.data;
		end
	end

	// outputs
	assign dat_o = dat_q;
	assign ack_o = ack_q;
	assign secure_o = secure;
	assign acc_block_o = secure & acc_req_i & ~acc_secure_src_i;
	assign cmd_start_o = kw & ~key_acc_q;
	assign cmd_accept_o = cmd_i.valid & ~cmd_bad;
	assign vector_redirect_en_o = ~opt_q[flash_sec_pkg::BIT_NO_REDIR];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence key_done_s;
		acc_fall && key_en && key_full && key_same;
	endsequence

	sequence stays_unsec_s;
		!secure_o [*3];
	endsequence

	sequence bus_req_s;
		cyc_i && stb_i && !ack_o;
	endsequence

	sequence ack_once_s;
		ack_o ##1 !ack_o;
	endsequence

	key_unlock_a: assert property (key_done_s |=> stays_unsec_s)
		else $error("matching key did not unlock");
	blank_unlock_a: assert property (blank_pass_i |=> lock_q == 2'h2)
		else $error("blank pass did not unlock");
	backdoor_key_enable_gate_a: assert property (!key_en && !blank_pass_i && secure_o
		|=> secure_o)
		else $error("unlock without key enable");
	debug_key_a: assert property (kw && key_wr_i.from_debug && !acc_fall
		|=> $stable(key_cnt_q))
		else $error("debug key write captured");
	route_cmd_a: assert property (kw |-> cmd_start_o != key_acc_q)
		else $error("window write misrouted");
	prot_grow_a: assert property (wr_prot && ps_new > ps_q |=> $stable(ps_q))
		else $error("protection shrank");
	viol_set_a: assert property (refuse |=> viol_q && !$past(cmd_accept_o))
		else $error("violation not flagged");
	mass_refuse_a: assert property (cmd_i.valid && cmd_i.mass && ps_q != 6'h3F
		|-> !cmd_accept_o)
		else $error("mass erase with protection");
	top_range_a: assert property (cmd_i.valid && ps_q == 6'h3E
		&& cmd_i.addr >= 16'hFA00 |-> !cmd_accept_o)
		else $error("top sector not protected");
	full_range_a: assert property (cmd_i.valid && !cmd_i.mass && ps_q == 6'h19
		&& cmd_i.addr < 16'h1C00 |-> cmd_accept_o)
		else $error("range start wrong");
	block_acc_a: assert property (acc_req_i && !acc_secure_src_i && lock_q != 2'h2
		|-> acc_block_o)
		else $error("unsecured access passed");
	redirect_a: assert property (vector_redirect_en_o == !opt_q[6])
		else $error("redirection wrong");
	opt_hold_a: assert property (wr |=> $stable(opt_q))
		else $error("option changed by write");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");

	// bus handshake: one wait state, one-cycle ack, upper read bits zero
	bus_answer_a: assert property (bus_req_s |=> ack_once_s)
		else $error("request not answered in one cycle");
	rd_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
		else $error("read data above bit seven not zero");

	// lock state only ever moves to unsecured, and only on its two events
	lock_keep_a: assert property (!secure_o |=> !secure_o)
		else $error("unlocked state lost before reset");
	lock_hold_a: assert property (secure_o && !blank_pass_i && !acc_fall
		|=> secure_o)
		else $error("lock left without key end or blank pass");
	bad_key_a: assert property (acc_fall && !(key_full && key_same) && !blank_pass_i
		&& secure_o |=> secure_o)
		else $error("incomplete or wrong key unlocked");

	// key capture counts only accepted in-order bytes
	key_count_a: assert property (kw_take && kw_order && !key_full && !acc_fall
		|=> key_cnt_q == $past(key_cnt_q) + 4'h1)
		else $error("key byte not counted");
	cfg_keep_a: assert property (!wr_cfg |=> $stable(key_acc_q))
		else $error("key access changed without a write");

	// protection register and violation flag
	prot_take_a: assert property (wr_prot && ps_new <= ps_q
		|=> ps_q == $past(ps_new))
		else $error("growing protection write lost");
	prot_keep_a: assert property (!wr_prot |=> $stable(ps_q))
		else $error("protection changed without a write");
	viol_hold_a: assert property (viol_q && !wr_stat |=> viol_q)
		else $error("violation flag dropped by itself");
	viol_clear_a: assert property (wr_stat && dat_i[flash_sec_pkg::BIT_VIOL] && !refuse
		|=> !viol_q)
		else $error("violation flag not cleared");
	mass_free_a: assert property (cmd_i.valid && cmd_i.mass && ps_q == flash_sec_pkg::PS_NONE
		|-> cmd_accept_o)
		else $error("mass erase refused without protection");

	// memory access gating
	secure_src_a: assert property (acc_req_i && acc_secure_src_i |-> !acc_block_o)
		else $error("secure source access blocked");
	unsec_pass_a: assert property (acc_req_i && !secure_o |-> !acc_block_o)
		else $error("access blocked while unsecured");
endmodule
`default_nettype wire

/* File: tb/tb_flash_security_protection.sv */
// self-checking bench of the flash security and protection block
`timescale 1ns/100ps
`default_nettype none
module tb_flash_security_protection;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h00000000;
	logic we_i = 1'b0;
	logic [3:0] sel_i = 4'hF;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic [7:0] nv_option_byte_i = 8'h00;
	logic [7:0] nv_protection_byte_i = 8'h3F;
	logic [63:0] nv_backdoor_key_i = 64'h0;
	flash_sec_pkg::key_wr_t key_wr_i = '0;
	flash_sec_pkg::flash_cmd_t cmd_i = '0;
	logic blank_pass_i = 1'b0;
	logic acc_req_i = 1'b0;
	logic acc_secure_src_i = 1'b0;
	logic [31:0] dat_o;
	logic ack_o, acc_block_o, cmd_start_o, cmd_accept_o, secure_o, vector_redirect_en_o;
	int error_cnt = 0;
	int checks_done = 0;
	logic [31:0] rd;
	logic [7:0] opt, prot, nps;
	logic [16:0] st;
	logic sec;

	always #12.5 clk_i = ~clk_i;

	flash_security_protection dut_u (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
		.we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
		.nv_option_byte_i(nv_option_byte_i), .nv_protection_byte_i(nv_protection_byte_i),
		.nv_backdoor_key_i(nv_backdoor_key_i), .key_wr_i(key_wr_i), .cmd_i(cmd_i),
		.blank_pass_i(blank_pass_i), .acc_req_i(acc_req_i), .acc_secure_src_i(acc_secure_src_i),
		.acc_block_o(acc_block_o), .cmd_start_o(cmd_start_o), .cmd_accept_o(cmd_accept_o),
		.secure_o(secure_o), .vector_redirect_en_o(vector_redirect_en_o));

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// classic cycle; request held until ack is sampled, then released
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		{adr_i, we_i, dat_i, cyc_i, stb_i} <= {a, w, 24'h0, d, 2'b11};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			give_verdict();
		end
		q = dat_o;
		{cyc_i, stb_i, we_i} <= 3'b000;
	endtask

	task automatic do_reset(input logic [7:0] o, input logic [7:0] p, input logic [63:0] k);
		@(posedge clk_i);
		{nv_option_byte_i, nv_protection_byte_i, nv_backdoor_key_i, rst_i} <= {o, p, k, 1'b1};
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask

	// first protected address for a select code
	function automatic logic [16:0] prot_start(input logic [5:0] c);
		if (c == flash_sec_pkg::PS_NONE) return flash_sec_pkg::MEM_TOP;
		if (c <= flash_sec_pkg::PS_FULL_MAX) return 17'h00000;
		return flash_sec_pkg::MEM_TOP - 17'(6'h3F - c) * flash_sec_pkg::PS_STEP;
	endfunction

	// launch check, then the sticky flag and its write-one clear
	task automatic try_cmd(input logic m, input logic [15:0] a, input logic ok);
		@(posedge clk_i);
		cmd_i <= '{1'b1, m, a};
		@(negedge clk_i);
		chk(cmd_accept_o, ok);
		@(posedge clk_i);
		cmd_i <= '0;
		bus(flash_sec_pkg::OFF_STATUS, 1'b0, 8'h00, rd);
		chk(rd[flash_sec_pkg::BIT_VIOL], !ok);
		bus(flash_sec_pkg::OFF_STATUS, 1'b1, 8'h20, rd);
		bus(flash_sec_pkg::OFF_STATUS, 1'b0, 8'h00, rd);
		chk(rd[flash_sec_pkg::BIT_VIOL], 1'b0);
	endtask

	task automatic send_key(input logic [63:0] k, input logic dbg, input logic start);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			key_wr_i <= '{1'b1, dbg, i[2:0], k[8*i +: 8]};
			@(negedge clk_i);
			chk(cmd_start_o, start);
		end
		@(posedge clk_i);
		key_wr_i <= '0;
	endtask

	initial begin
		void'($urandom(32'h7934));
		for (int it = 0; it < 9; it++) begin
			opt = $urandom;
			prot = $urandom;
			// corner codes: nothing, lowest partial, first full, topmost partial
			case (it)
				0: prot[5:0] = flash_sec_pkg::PS_NONE;
				1: prot[5:0] = 6'h19;
				2: prot[5:0] = flash_sec_pkg::PS_FULL_MAX;
				3: prot[5:0] = 6'h3E;
				default: ;
			endcase
			do_reset(opt, prot, {$urandom, $urandom});
			sec = (opt[1:0] != flash_sec_pkg::LOCK_UNSEC);
			bus(flash_sec_pkg::OFF_OPTION, 1'b1, ~opt, rd);
			bus(flash_sec_pkg::OFF_OPTION, 1'b0, 8'h00, rd);
			chk(rd, {24'h0, opt});
			chk(secure_o, sec);
			chk(vector_redirect_en_o, !opt[6]);
			bus(8'h10, 1'b0, 8'h00, rd);
			chk(rd, flash_sec_pkg::RD_ZERO);
			// unsecured-source access is blocked only while locked
			@(posedge clk_i);
			{acc_req_i, acc_secure_src_i} <= 2'b10;
			@(negedge clk_i);
			chk(acc_block_o, sec);
			@(posedge clk_i);
			{acc_req_i, acc_secure_src_i} <= 2'b11;
			@(negedge clk_i);
			chk(acc_block_o, 1'b0);
			@(posedge clk_i);
			{acc_req_i, acc_secure_src_i} <= 2'b00;
			bus(flash_sec_pkg::OFF_PROTECT, 1'b0, 8'h00, rd);
			chk(rd, {26'h0, prot[5:0]});
			st = prot_start(prot[5:0]);
			if (st != 17'h00000) try_cmd(1'b0, 16'(st - 17'h1), 1'b1);
			if (st != flash_sec_pkg::MEM_TOP) try_cmd(1'b0, st[15:0], 1'b0);
			try_cmd(1'b1, 16'($urandom), prot[5:0] == flash_sec_pkg::PS_NONE);
			// a write without the low byte lane is ignored
			sel_i <= 4'hE;
			bus(flash_sec_pkg::OFF_PROTECT, 1'b1, 8'h00, rd);
			sel_i <= 4'hF;
			// region may only grow; a larger code is dropped
			nps = $urandom;
			bus(flash_sec_pkg::OFF_PROTECT, 1'b1, {2'b00, nps[5:0]}, rd);
			bus(flash_sec_pkg::OFF_PROTECT, 1'b0, 8'h00, rd);
			chk(rd, {26'h0, (nps[5:0] <= prot[5:0]) ? nps[5:0] : prot[5:0]});
			// window writes go to commands while key access is off
			send_key(nv_backdoor_key_i, 1'b0, 1'b1);
			bus(flash_sec_pkg::OFF_CONFIG, 1'b1, 8'h60, rd);
			bus(flash_sec_pkg::OFF_CONFIG, 1'b0, 8'h00, rd);
			chk(rd, 32'h00000060);
			send_key(nv_backdoor_key_i ^ {63'h0, it % 3 == 2}, it % 3 == 1, 1'b0);
			bus(flash_sec_pkg::OFF_CONFIG, 1'b1, 8'h40, rd);
			@(negedge clk_i);
			chk(secure_o, (it % 3 == 0 && opt[7]) ? 1'b0 : sec);
			bus(flash_sec_pkg::OFF_CONFIG, 1'b0, 8'h00, rd);
			chk(rd, 32'h00000040);
			@(posedge clk_i);
			blank_pass_i <= 1'b1;
			@(posedge clk_i);
			blank_pass_i <= 1'b0;
			bus(flash_sec_pkg::OFF_STATUS, 1'b0, 8'h00, rd);
			chk(rd[flash_sec_pkg::BIT_SECURE], 1'b0);
			$display("test %0d done", it);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
